// file: rtl/nco_regs.vh
// Register map, field positions, widths, encodings and reset values of the
// oscillator output stage. Assumes inclusion by its bare name.
`ifndef NCO_REGS_VH
`define NCO_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define NCO_OFS_CTRL 12'h000
`define NCO_OFS_CLK 12'h004
`define NCO_OFS_INC 12'h008
`define NCO_OFS_ACC 12'h00C
`define NCO_OFS_IFLAG 12'h010
`define NCO_OFS_IEN 12'h014
`define NCO_OFS_ICTL 12'h018
`define NCO_OFS_APF 12'h01C

// ****************************************************************
// Field positions
// ****************************************************************
`define NCO_CTRL_EN 7
`define NCO_CTRL_OUT 5
`define NCO_CTRL_POL 4
`define NCO_CTRL_PFM 0
`define NCO_CLK_PWS_HI 7
`define NCO_CLK_PWS_LO 5
`define NCO_CLK_SRC_HI 1
`define NCO_CLK_SRC_LO 0
`define NCO_CLK_DIV_HI 15
`define NCO_CLK_DIV_LO 8
`define NCO_IFLAG_OVF 0
`define NCO_IEN_OVF 0
`define NCO_ICTL_GIE 7
`define NCO_ICTL_PERIPHERAL_IRQ_ENABLE 6
`define NCO_APF_SEL 0

// ****************************************************************
// Widths, encodings, reset values
// ****************************************************************
`define NCO_ACC_W 20
`define NCO_INC_W 16
`define NCO_SRC_HFOSC 2'h0
`define NCO_RST_ZERO 32'h0000_0000
`define NCO_PW_CNT_W 8

`endif

// file: rtl/nco_output_stage.v
// Oscillator output stage: accumulator, mode logic, polarity, flag and
// enables, pin routing, all behind an AHB-Lite slave.
// Assumes one 250 MHz clock; the source clock is an enable from a divider.
// Sleep and source select come from same-clock logic, so they are not
// synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "nco_regs.vh"

module nco_output_stage (
    input wire sys_clk_i, // 250 MHz clock
    input wire rst_n_i, // Async reset, active low
    input wire hsel_i, // Slave select
    input wire [11:0] haddr_i, // Byte address
    input wire [1:0] htrans_i, // Transfer type
    input wire hwrite_i, // Write when high
    input wire [2:0] hsize_i, // Transfer size
    input wire [31:0] hwdata_i, // Write data
    input wire hready_i, // Bus ready
    output reg [31:0] hrdata_o, // Read data
    output reg hreadyout_o, // Slave ready
    output reg hresp_o, // Always OKAY
    input wire sleep_i, // Core is asleep
    output reg hfosc_keep_o, // Keep fast oscillator on
    output reg cpu_irq_o, // Interrupt request to core
    output reg clc_out_o, // Output to logic cell
    output reg cwg_out_o, // Output to waveform generator
    output reg pin_dflt_o, // Default pin data
    output reg pin_dflt_oe_n_o, // Default pin enable, low drives
    output reg pin_alt_o, // Alternate pin data
    output reg pin_alt_oe_n_o // Alternate pin enable, low drives
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    // Software-visible fields, all zero after reset
    reg oscillator_enable_r;
    reg output_polarity_r;
    reg pulse_freq_mode_sel_r;
    reg [2:0] pulse_width_sel_r;
    reg [1:0] clk_src_sel_r;
    reg [7:0] clk_div_r;
    reg [`NCO_INC_W-1:0] inc_r;
    reg [`NCO_ACC_W-1:0] acc_r;
    reg overflow_irq_flag_r;
    reg overflow_irq_enable_r;
    reg global_irq_enable_r;
    reg peripheral_irq_enable_r;
    reg alt_pin_sel_r;

    // Datapath state
    reg [7:0] div_cnt_r;
    reg src_tick_r;
    reg fdc_q_r;
    reg pf_q_r;
    // Pulse counter covers the longest width, 128 ticks
    reg [`NCO_PW_CNT_W-1:0] pw_cnt_r;
    reg out_pol_r;

    // Bus data phase capture
    // Address of a write is held for its data phase
    reg wr_pend_r;
    reg [11:0] wr_addr_r;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Width field n gives 2**n source periods
    function [`NCO_PW_CNT_W-1:0] pw_len;
        input [2:0] sel;
        begin
            pw_len = 8'h01 << sel;
        end
    endfunction

    // Word address of a byte address; the two low bits never select
    function [11:0] word_addr;
        input [11:0] a;
        begin
            word_addr = {a[11:2], 2'b00};
        end
    endfunction

    // Write in its data phase hitting one word; all state is passed in
    // so that continuous assignments see every change
    function wr_hit;
        input pend;
        input [11:0] at;
        input [11:0] a;
        begin
            wr_hit = pend & (at == a);
        end
    endfunction

    // Read mux, looked up in the address phase: a read right after a
    // write to the same word returns the old value
    function [31:0] reg_read;
        input [11:0] a;
        begin
            // Only mapped fields are driven; every other bit reads zero
            reg_read = `NCO_RST_ZERO;
            case (a)
                `NCO_OFS_CTRL: begin
                    reg_read[`NCO_CTRL_EN] = oscillator_enable_r;
                    reg_read[`NCO_CTRL_OUT] = out_pol_r;
                    reg_read[`NCO_CTRL_POL] = output_polarity_r;
                    reg_read[`NCO_CTRL_PFM] = pulse_freq_mode_sel_r;
                end
                `NCO_OFS_CLK: begin
                    reg_read[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO] =
                        pulse_width_sel_r;
                    reg_read[`NCO_CLK_SRC_HI:`NCO_CLK_SRC_LO] =
                        clk_src_sel_r;
                    reg_read[`NCO_CLK_DIV_HI:`NCO_CLK_DIV_LO] = clk_div_r;
                end
                `NCO_OFS_INC: reg_read[`NCO_INC_W-1:0] = inc_r;
                `NCO_OFS_ACC: reg_read[`NCO_ACC_W-1:0] = acc_r;
                `NCO_OFS_IFLAG:
                    reg_read[`NCO_IFLAG_OVF] = overflow_irq_flag_r;
                `NCO_OFS_IEN:
                    reg_read[`NCO_IEN_OVF] = overflow_irq_enable_r;
                `NCO_OFS_ICTL: begin
                    reg_read[`NCO_ICTL_GIE] = global_irq_enable_r;
                    reg_read[`NCO_ICTL_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_r;
                end
                `NCO_OFS_APF: reg_read[`NCO_APF_SEL] = alt_pin_sel_r;
                default: reg_read = `NCO_RST_ZERO;
            endcase
        end
    endfunction

    // ****************************************************************
    // Combinational next values
    // ****************************************************************
    // Address phase taken when selected and ready
    wire bus_take = hsel_i & htrans_i[1] & hready_i;
    wire wr_ctrl = wr_hit(wr_pend_r, wr_addr_r, `NCO_OFS_CTRL);
    wire wr_iflag = wr_hit(wr_pend_r, wr_addr_r, `NCO_OFS_IFLAG);
    // One spare bit keeps the carry of the addition
    wire [`NCO_ACC_W:0] acc_sum =
        {1'b0, acc_r} + {{(`NCO_ACC_W+1-`NCO_INC_W){1'b0}}, inc_r};
    // Carry out of the top bit marks a wrap
    wire wrap = oscillator_enable_r & src_tick_r & acc_sum[`NCO_ACC_W];
    // The polarity being written counts in its own data phase, so the
    // output and the flag move at the same edge
    wire pol_nxt = wr_ctrl ? hwdata_i[`NCO_CTRL_POL] : output_polarity_r;
    wire pol_flip = wr_ctrl & (pol_nxt != output_polarity_r);
    // Next values of the shapers, built in the process below
    reg raw_nxt;
    reg fdc_nxt;
    reg pf_nxt;
    reg [`NCO_PW_CNT_W-1:0] pw_cnt_nxt;

    // Mode logic on source ticks; disabled module idles inactive
    always @* begin
        fdc_nxt = fdc_q_r;
        pf_nxt = pf_q_r;
        pw_cnt_nxt = pw_cnt_r;
        // Disabling clears the shapers so a new start begins inactive
        if (!oscillator_enable_r) begin
            fdc_nxt = 1'b0;
            pf_nxt = 1'b0;
            pw_cnt_nxt = 8'h00;
        end else if (src_tick_r) begin
            // Width is taken at the wrap; a change mid-pulse waits
            // A width longer than the wrap spacing restarts every wrap
            if (wrap) begin
                fdc_nxt = ~fdc_q_r;
                pf_nxt = 1'b1;
                pw_cnt_nxt = pw_len(pulse_width_sel_r) - 8'h01;
            end else if (pw_cnt_r != 8'h00) begin
                pw_cnt_nxt = pw_cnt_r - 8'h01;
            end else begin
                pf_nxt = 1'b0;
            end
        end
        // Mode select chooses between the two shapers
        if (pulse_freq_mode_sel_r) begin
            raw_nxt = pf_nxt;
        end else begin
            raw_nxt = fdc_nxt;
        end
    end

    // Polarity as the last stage, using the polarity being written
    wire out_nxt = raw_nxt ^ pol_nxt;

    // ****************************************************************
    // Source clock divider: one-cycle enable every clk_div+1 cycles
    // ****************************************************************
    // A divider of zero ticks every cycle; one lowered below the
    // running count ticks at once
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_r <= 8'h00;
            src_tick_r <= 1'b0;
        end else if (div_cnt_r >= clk_div_r) begin
            div_cnt_r <= 8'h00;
            src_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            src_tick_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Accumulator and output shaping
    // ****************************************************************
    // Sleep is not looked at: the stage runs on its own source
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= {`NCO_ACC_W{1'b0}};
            fdc_q_r <= 1'b0;
            pf_q_r <= 1'b0;
            pw_cnt_r <= 8'h00;
            out_pol_r <= 1'b0;
        end else begin
            // A software load of the accumulator wins over the addition
            if (wr_hit(wr_pend_r, wr_addr_r, `NCO_OFS_ACC)) begin
                acc_r <= hwdata_i[`NCO_ACC_W-1:0];
            end else if (oscillator_enable_r & src_tick_r) begin
                acc_r <= acc_sum[`NCO_ACC_W-1:0];
            end
            fdc_q_r <= fdc_nxt;
            pf_q_r <= pf_nxt;
            pw_cnt_r <= pw_cnt_nxt;
            out_pol_r <= out_nxt;
        end
    end

    // ****************************************************************
    // AHB-Lite slave: zero wait, read data fetched in address phase
    // ****************************************************************
    // No wait states: ready rises on the first edge after reset
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_o <= `NCO_RST_ZERO;
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_r <= bus_take & hwrite_i;
            if (bus_take) begin
                wr_addr_r <= word_addr(haddr_i);
            end
            if (bus_take & ~hwrite_i) begin
                hrdata_o <= reg_read(word_addr(haddr_i));
            end
        end
    end

    // Register writes in the data phase; all clear to zero on reset
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oscillator_enable_r <= 1'b0;
            output_polarity_r <= 1'b0;
            pulse_freq_mode_sel_r <= 1'b0;
            pulse_width_sel_r <= 3'h0;
            clk_src_sel_r <= 2'h0;
            clk_div_r <= 8'h00;
            inc_r <= {`NCO_INC_W{1'b0}};
            overflow_irq_enable_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
            alt_pin_sel_r <= 1'b0;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `NCO_OFS_CTRL: begin
                    // Bit 5 is read-only, so a write to it is dropped
                    oscillator_enable_r <= hwdata_i[`NCO_CTRL_EN];
                    output_polarity_r <= hwdata_i[`NCO_CTRL_POL];
                    pulse_freq_mode_sel_r <= hwdata_i[`NCO_CTRL_PFM];
                end
                `NCO_OFS_CLK: begin
                    // Source bits only steer the oscillator keep-alive
                    pulse_width_sel_r <=
                        hwdata_i[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
                    clk_src_sel_r <=
                        hwdata_i[`NCO_CLK_SRC_HI:`NCO_CLK_SRC_LO];
                    clk_div_r <= hwdata_i[`NCO_CLK_DIV_HI:`NCO_CLK_DIV_LO];
                end
                `NCO_OFS_INC: inc_r <= hwdata_i[`NCO_INC_W-1:0];
                `NCO_OFS_IEN:
                    overflow_irq_enable_r <= hwdata_i[`NCO_IEN_OVF];
                `NCO_OFS_ICTL: begin
                    global_irq_enable_r <= hwdata_i[`NCO_ICTL_GIE];
                    peripheral_irq_enable_r <= hwdata_i[`NCO_ICTL_PERIPHERAL_IRQ_ENABLE];
                end
                `NCO_OFS_APF: alt_pin_sel_r <= hwdata_i[`NCO_APF_SEL];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Overflow flag: set wins over a software clear
    // ****************************************************************
    // Wrap is already in this clock's domain, one tick per wrap
    // A polarity change with the overflow enable set raises it too
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_irq_flag_r <= 1'b0;
        end else if (wrap | (pol_flip & overflow_irq_enable_r)) begin
            overflow_irq_flag_r <= 1'b1;
        end else if (wr_iflag) begin
            overflow_irq_flag_r <= hwdata_i[`NCO_IFLAG_OVF];
        end
    end

    // ****************************************************************
    // Outputs: irq gating, routing, pins, oscillator keep-alive
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_irq_o <= 1'b0;
            clc_out_o <= 1'b0;
            cwg_out_o <= 1'b0;
            pin_dflt_o <= 1'b0;
            pin_dflt_oe_n_o <= 1'b1;
            pin_alt_o <= 1'b0;
            pin_alt_oe_n_o <= 1'b1;
            hfosc_keep_o <= 1'b0;
        end else begin
            // Request trails the flag by one cycle
            cpu_irq_o <= overflow_irq_flag_r & oscillator_enable_r &
                overflow_irq_enable_r & peripheral_irq_enable_r &
                global_irq_enable_r;
            // Both taps carry the same level
            clc_out_o <= out_nxt;
            cwg_out_o <= out_nxt;
            // Only the selected location drives, and only while enabled; the other floats
            pin_dflt_o <= out_nxt;
            pin_alt_o <= out_nxt;
            pin_dflt_oe_n_o <= alt_pin_sel_r | ~oscillator_enable_r;
            pin_alt_oe_n_o <= ~alt_pin_sel_r | ~oscillator_enable_r;
            // Fast oscillator held only while asleep and enabled on it
            hfosc_keep_o <= sleep_i & oscillator_enable_r &
                (clk_src_sel_r == `NCO_SRC_HFOSC);
        end
    end

endmodule // nco_output_stage
`default_nettype wire

// file: verif/nco_far_model.sv
// Far side of the output taps: logic cell and waveform generator inputs.
// Assumes both taps are sampled on the system clock.
`timescale 1ns/10ps
`default_nettype none

module nco_far_model (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic clc_in_i, // Logic cell tap
    input wire logic cwg_in_i, // Waveform tap
    output logic [15:0] clc_rises_o, // Rises on cell tap
    output logic [15:0] cwg_rises_o // Rises on waveform tap
);
    logic clc_d_r;
    logic cwg_d_r;

    // ****************
    // Edge counting; both peripherals must see one waveform
    // ****************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clc_d_r <= 1'b0;
            cwg_d_r <= 1'b0;
            clc_rises_o <= 16'h0000;
            cwg_rises_o <= 16'h0000;
        end else begin
            clc_d_r <= clc_in_i;
            cwg_d_r <= cwg_in_i;
            clc_rises_o <= clc_rises_o + 16'(clc_in_i & ~clc_d_r);
            cwg_rises_o <= cwg_rises_o + 16'(cwg_in_i & ~cwg_d_r);
        end
    end
endmodule // nco_far_model

`default_nettype wire

// file: verif/nco_out_asserts.sv
// Port checker of the oscillator output stage.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module nco_out_asserts (
    input wire logic sys_clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic hsel_i, // Select
    input wire logic [11:0] haddr_i, // Address
    input wire logic [1:0] htrans_i, // Transfer
    input wire logic hwrite_i, // Write
    input wire logic [2:0] hsize_i, // Size
    input wire logic [31:0] hwdata_i, // Write data
    input wire logic hready_i, // Ready in
    input wire logic [31:0] hrdata_o, // Read data
    input wire logic hreadyout_o, // Ready out
    input wire logic hresp_o, // Response
    input wire logic sleep_i, // Sleep
    input wire logic hfosc_keep_o, // Keep osc
    input wire logic cpu_irq_o, // Irq
    input wire logic clc_out_o, // Cell tap
    input wire logic cwg_out_o, // Waveform tap
    input wire logic pin_dflt_o, // Default pin
    input wire logic pin_dflt_oe_n_o, // Default enable
    input wire logic pin_alt_o, // Alternate pin
    input wire logic pin_alt_oe_n_o // Alternate enable
);
    logic rd_take;

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Read requests, the cause of most data checks
    assign rd_take = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;

    ready_ok_a: assert property ($past(rst_n_i) |-> hreadyout_o)
        else $error("slave not ready");
    okay_resp_a: assert property (!hresp_o) else $error("bad response");
    taps_same_a: assert property (clc_out_o == cwg_out_o)
        else $error("taps differ");
    pin_single_a: assert property (pin_dflt_oe_n_o | pin_alt_oe_n_o)
        else $error("two pins drive");
    dflt_data_a: assert property (!pin_dflt_oe_n_o |->
        pin_dflt_o == clc_out_o) else $error("default pin data");
    alt_data_a: assert property (!pin_alt_oe_n_o |->
        pin_alt_o == clc_out_o) else $error("alternate pin data");
    keep_sleep_a: assert property (hfosc_keep_o |-> $past(sleep_i))
        else $error("osc kept while awake");
    reset_clear_a: assert property ($rose(rst_n_i) |->
        pin_dflt_oe_n_o && pin_alt_oe_n_o && !cpu_irq_o && !clc_out_o)
        else $error("outputs not cleared");
    unmapped_zero_a: assert property (rd_take && haddr_i[11:5] != 7'h00
        |=> hrdata_o == 32'h0000_0000) else $error("unmapped read");
    out_readback_a: assert property (rd_take && haddr_i[11:2] == 10'h000
        |=> hrdata_o[5] == $past(clc_out_o)) else $error("readback bit");

    cover property ($rose(clc_out_o));
    cover property (cpu_irq_o);
    cover property (hfosc_keep_o);
endmodule // nco_out_asserts

bind nco_output_stage nco_out_asserts nco_out_asserts_inst (.*);

`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the oscillator output stage over AHB-Lite.
// Assumes the design's zero-wait slave and its register header.
`timescale 1ns/10ps
`default_nettype none
`include "nco_regs.vh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
    bad_count++; $display("CHECK FAILED %0t %s", $time, m); end end

module testbench;
    logic sys_clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, sleep_i = 0;
    logic [11:0] haddr_i = 0;
    logic [1:0] htrans_i = 0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 0, hrdata_o, rd_q[$];
    logic hreadyout_o, hresp_o, hfosc_keep_o, cpu_irq_o, clc_out_o;
    logic cwg_out_o, pin_dflt_o, pin_dflt_oe_n_o, pin_alt_o, pin_alt_oe_n_o;
    logic [15:0] clc_rises, cwg_rises;
    logic dp_rd = 0;
    wire hready_i = hreadyout_o;
    int bad_count = 0, n_compared = 0, n, a, b, nd;

    always #2 sys_clk_i = ~sys_clk_i;
    nco_output_stage nco_output_stage_inst (.*);
    nco_far_model nco_far_model_inst (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .clc_in_i(clc_out_o), .cwg_in_i(cwg_out_o),
        .clc_rises_o(clc_rises), .cwg_rises_o(cwg_rises));

    // ****************
    // Read monitor: data phase against the oldest note
    // ****************
    always @(posedge sys_clk_i)
        dp_rd <= hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    always @(negedge sys_clk_i)
        if (dp_rd) `CHK(hrdata_o, rd_q.pop_front(), "read")

    task end_of_test;
        $display("compared %0d, failed %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for ready at a rising edge
    task rdy;
        int i;
        i = 0;
        do begin
            @(posedge sys_clk_i);
            i++;
            if (i > 100) begin bad_count++; end_of_test; end
        end while (hreadyout_o !== 1'b1);
    endtask

    // One single word transfer; a read notes its expected data
    task automatic bus(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        if (!w) rd_q.push_back(d);
        @(posedge sys_clk_i);
        hsel_i <= 1; haddr_i <= ad; htrans_i <= 2'h2; hwrite_i <= w;
        rdy;
        hsel_i <= 0; htrans_i <= 2'h0;
        if (w) hwdata_i <= d;
        rdy;
    endtask

    // Cycles until the output tap shows a level; bounded
    task lvl(input logic v, output int c);
        c = 0;
        while (clc_out_o !== v) begin
            @(negedge sys_clk_i);
            c++;
            if (c > 5000) begin bad_count++; end_of_test; end
        end
    endtask

    initial begin
        void'($urandom(53962));
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1;
        // Reset values and one unmapped word
        for (int i = 0; i < 9; i++) bus(0, 12'(i * 4), 32'h0000_0000);
        bus(1, 12'h020, $urandom);
        bus(0, 12'h020, 32'h0000_0000);
        $display("done: reset and map");
        // Fixed duty, random divider, asleep until the oscillator is released
        nd = $urandom % 4;
        sleep_i <= 1;
        bus(1, `NCO_OFS_CLK, 32'(nd) << 8);
        bus(1, `NCO_OFS_INC, 32'h0000_8000);
        bus(1, `NCO_OFS_CTRL, 32'h0000_0080);
        lvl(0, n); lvl(1, n); lvl(0, a); lvl(1, b);
        `CHK(a + b, 64 * (nd + 1), "fdc period")
        `CHK(hfosc_keep_o, 1'b1, "osc kept")
        `CHK(clc_rises, cwg_rises, "taps")
        bus(0, `NCO_OFS_IFLAG, 32'h0000_0001);
        bus(1, `NCO_OFS_CLK, (32'(nd) << 8) | 32'h0000_0001);
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK(hfosc_keep_o, 1'b0, "osc released")
        sleep_i <= 0;
        bus(1, `NCO_OFS_CTRL, 32'h0000_0000);
        repeat (50) @(posedge sys_clk_i);
        bus(0, `NCO_OFS_IFLAG, 32'h0000_0001);
        bus(1, `NCO_OFS_IFLAG, 32'h0000_0000);
        bus(0, `NCO_OFS_IFLAG, 32'h0000_0000);
        $display("done: fixed duty");
        // Pulse mode, every width; wrap interval 256 ticks
        bus(1, `NCO_OFS_INC, 32'h0000_1000);
        bus(1, `NCO_OFS_CTRL, 32'h0000_0081);
        for (int p = 0; p < 8; p++) begin
            bus(1, `NCO_OFS_CLK, 32'(p) << 5);
            lvl(0, n); lvl(1, n); lvl(0, a); lvl(1, b);
            `CHK(a, 1 << p, "pulse width")
            `CHK(a + b, 256, "pulse spacing")
        end
        $display("done: pulse mode");
        // Polarity with the oscillator stopped
        bus(1, `NCO_OFS_CTRL, 32'h0000_0000);
        bus(1, `NCO_OFS_IFLAG, 32'h0000_0000);
        bus(1, `NCO_OFS_IEN, 32'h0000_0001);
        bus(1, `NCO_OFS_CTRL, 32'h0000_0010);
        @(negedge sys_clk_i);
        `CHK(clc_out_o, 1'b1, "polarity")
        bus(0, `NCO_OFS_CTRL, 32'h0000_0030);
        bus(0, `NCO_OFS_IFLAG, 32'h0000_0001);
        $display("done: polarity");
        // Every enable combination; no wraps with a zero increment
        bus(1, `NCO_OFS_INC, 32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            bus(1, `NCO_OFS_CTRL, 32'(k[0]) << 7);
            bus(1, `NCO_OFS_IEN, 32'(k[1]));
            bus(1, `NCO_OFS_ICTL, 32'(k[3:2]) << 6);
            bus(1, `NCO_OFS_IFLAG, 32'h0000_0001);
            repeat (3) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            `CHK(cpu_irq_o, &k[3:0], "irq gate")
            `CHK(pin_dflt_oe_n_o, !k[0], "default pin")
        end
        bus(1, `NCO_OFS_APF, 32'h0000_0001);
        // Pin enables follow the select one edge after the write
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK(pin_alt_oe_n_o, 1'b0, "alternate pin")
        `CHK(pin_dflt_oe_n_o, 1'b1, "default released")
        $display("done: irq and pins");
        // Second reset in mid-run
        @(posedge sys_clk_i);
        rst_n_i <= 0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1;
        bus(0, `NCO_OFS_APF, 32'h0000_0000);
        bus(0, `NCO_OFS_CTRL, 32'h0000_0000);
        bus(0, `NCO_OFS_ICTL, 32'h0000_0000);
        $display("done: second reset");
        end_of_test;
    end
endmodule // testbench

`default_nettype wire
